// [logic/tsr_pkg.sv]
// Package of constants and carriers for the touch status and result registers
package tsr_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] TSR_OFS_STATUS = 8'h00;
	localparam logic [7:0] TSR_OFS_BUTTON = 8'h01;
	localparam logic [7:0] TSR_OFS_RESULT_BASE = 8'h02;
	localparam int TSR_RESULT_CHANNELS = 3;
	localparam int TSR_CHANNELS = 4;
	localparam int TSR_DATA_W = 12;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int TSR_BIT_ANY_PRESS = 7;
	localparam int TSR_BIT_READY = 6;
	localparam int TSR_BIT_WRITE_PERMIT = 5;
	localparam int TSR_BIT_FULL_SCALE = 4;
	localparam int TSR_BIT_SEQ_FAULT = 3;
	localparam int TSR_BIT_OSC_FAULT = 2;
	localparam int TSR_BIT_HOLD_TIMEOUT = 1;
	localparam int TSR_BIT_REG_CHANGE = 0;
	localparam int TSR_BIT_DATA_READY = 4;

	// ------------------------------------------------------------
	// Reset values and limits
	// ------------------------------------------------------------
	localparam logic [7:0] TSR_RST_STATUS = 8'h40;
	localparam logic [7:0] TSR_RST_BUTTON = 8'h00;
	localparam logic [7:0] TSR_RST_RESULT = 8'h00;
	localparam logic [11:0] TSR_FULL_POS = 12'h7ff;
	localparam logic [11:0] TSR_FULL_NEG = 12'h800;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam longint TSR_CLK_HZ = 100_000_000;
	localparam longint TSR_HOLD_TIMEOUT_S = 50;
	localparam longint TSR_HOLD_TIMEOUT_CYC = TSR_HOLD_TIMEOUT_S * TSR_CLK_HZ;

	// Event inputs from the scan engine, one cycle pulses or levels
	typedef struct packed {
		logic seq_fault;
		logic osc_fault;
		logic reg_change;
		logic sample_done;
	} tsr_event_s;

	// Register read port request
	typedef struct packed {
		logic rd;
		logic [7:0] addr;
	} tsr_rd_req_s;

endpackage

// [logic/tsr_regs.sv]
// Status, button state and result registers of the touch sensing device
// Notes on behaviour
// - status bit7 ORs presses, cleared by read
// - status bit6 shows ready, resets to one
// - status bit5 shows registers accept writes
// - status bit4 sets at full scale data
// - status bit3 sets on sequencer fault
// - status bit2 sets on oscillator start fault
// - status bit1 sets after 50 s hold
// - hold timeout disable suppresses the timeout flag
// - status bit0 sets on unexpected register change
// - button bit4 new data, cleared by read
// - button bits3..0 give channel press states
// - results 12-bit, split low/high byte
// - channel pairs at 2h/3h, 4h/5h, 6h/7h
// - reserved bits read as zero
// - undefined offsets reserved, read as zero
`timescale 1ns/1ns

module tsr_regs #(
	parameter longint HOLD_TIMEOUT_CYC = tsr_pkg::TSR_HOLD_TIMEOUT_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire tsr_pkg::tsr_rd_req_s rd_req_i,
	output logic [7:0] rd_data_o,
	input wire logic chip_ready_i,
	input wire logic write_permit_flag_i,
	input wire logic hold_timeout_disable_i,
	input wire logic [3:0] button_pressed_bits_i,
	input wire tsr_pkg::tsr_event_s event_i,
	input wire logic result_valid_i,
	input wire logic [35:0] result_data_i
);
	import tsr_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic any_press_reg;
	logic full_scale_flag_reg;
	logic sequencer_fault_flag_reg;
	logic oscillator_start_fault_reg;
	logic hold_timeout_reg;
	logic reg_change_reg;
	logic data_ready_reg;
	logic [11:0] result_reg [TSR_RESULT_CHANNELS];
	logic [35:0] hold_cnt_reg;
	logic [35:0] hold_cnt_next;
	logic [3:0] press_reg;
	logic [2:0] full_hit;
	logic status_rd;
	logic button_rd;
	logic timeout_hit;
	logic [7:0] rd_data_next;

	assign status_rd = ce_i && rd_req_i.rd && (rd_req_i.addr == TSR_OFS_STATUS);
	assign button_rd = ce_i && rd_req_i.rd && (rd_req_i.addr == TSR_OFS_BUTTON);

	// ------------------------------------------------------------
	// Result capture per channel
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < TSR_RESULT_CHANNELS; g++) begin : g_res
			// Full scale detected on the incoming word, so a brief peak is not missed
			assign full_hit[g] = result_valid_i &&
				((result_data_i[g*12 +: 12] == TSR_FULL_POS) ||
				(result_data_i[g*12 +: 12] == TSR_FULL_NEG));
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					result_reg[g] <= 12'h000;
				end else if (ce_i && result_valid_i) begin
					result_reg[g] <= result_data_i[g*12 +: 12];
				end
			end

			// Each byte of the pair mirrors its own half of the stored word
			property p_res_lo;
				@(posedge clk_i) disable iff (rst_i)
				(ce_i && rd_req_i.rd && rd_req_i.addr == TSR_OFS_RESULT_BASE + 8'(2 * g))
					|=> rd_data_o == $past(result_reg[g][7:0]);
			endproperty
			a_res_lo: assert property (p_res_lo) else $error("bad low byte");

			property p_res_hi;
				@(posedge clk_i) disable iff (rst_i)
				(ce_i && rd_req_i.rd && rd_req_i.addr == TSR_OFS_RESULT_BASE + 8'(2 * g + 1))
					|=> rd_data_o == {4'h0, $past(result_reg[g][11:8])};
			endproperty
			a_res_hi: assert property (p_res_hi) else $error("bad high byte");

			// Any channel at either end of the range must raise the flag
			property p_full_set;
				@(posedge clk_i) disable iff (rst_i)
				(ce_i && full_hit[g]) |=> full_scale_flag_reg;
			endproperty
			a_full_set: assert property (p_full_set) else $error("full scale lost");
		end
	endgenerate

	// Press states registered for bits 3..0 and the hold timer; bit 7 samples the pins on its own
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			press_reg <= 4'h0;
		end else if (ce_i) begin
			press_reg <= button_pressed_bits_i;
		end
	end

	// State bits follow the pins one cycle late, reserved bits stay clear
	property p_press;
		@(posedge clk_i) disable iff (rst_i)
		button_rd |=> (rd_data_o[3:0] == $past(press_reg)) && (rd_data_o[7:5] == 3'b000);
	endproperty
	a_press: assert property (p_press) else $error("bad press bits");

	// ------------------------------------------------------------
	// Hold timer: restarts whenever no button is held
	// ------------------------------------------------------------
	always_comb begin
		hold_cnt_next = hold_cnt_reg;
		if (press_reg == 4'h0 || hold_timeout_disable_i) begin
			hold_cnt_next = 36'h0_0000_0000;
		end else if (hold_cnt_reg < 36'(HOLD_TIMEOUT_CYC)) begin
			hold_cnt_next = hold_cnt_reg + 36'h0_0000_0001;
		end
	end
	// Fires once per hold, in the cycle the count stands one below the limit
	assign timeout_hit = !hold_timeout_disable_i && (press_reg != 4'h0) &&
		(hold_cnt_reg == 36'(HOLD_TIMEOUT_CYC) - 36'h0_0000_0001);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_cnt_reg <= 36'h0_0000_0000;
		end else if (ce_i) begin
			hold_cnt_reg <= hold_cnt_next;
		end
	end

	// A count one below the limit must raise the flag on the next edge
	property p_hold_flag;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && timeout_hit) |=> hold_timeout_reg;
	endproperty
	a_hold_flag: assert property (p_hold_flag) else $error("hold timeout lost");

	// ------------------------------------------------------------
	// Sticky flags: set beats the clearing read
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			any_press_reg <= 1'b0;
			full_scale_flag_reg <= 1'b0;
			sequencer_fault_flag_reg <= 1'b0;
			oscillator_start_fault_reg <= 1'b0;
			hold_timeout_reg <= 1'b0;
			reg_change_reg <= 1'b0;
		end else if (ce_i) begin
			any_press_reg <= (|button_pressed_bits_i) ||
				(any_press_reg && !status_rd);
			full_scale_flag_reg <= (|full_hit) ||
				(full_scale_flag_reg && !status_rd);
			sequencer_fault_flag_reg <= event_i.seq_fault ||
				(sequencer_fault_flag_reg && !status_rd);
			oscillator_start_fault_reg <= event_i.osc_fault ||
				(oscillator_start_fault_reg && !status_rd);
			hold_timeout_reg <= timeout_hit ||
				(hold_timeout_reg && !status_rd);
			reg_change_reg <= event_i.reg_change ||
				(reg_change_reg && !status_rd);
		end
	end

	// Press summary drops on a read once no button is held
	property p_press_clr;
		@(posedge clk_i) disable iff (rst_i)
		(status_rd && !(|button_pressed_bits_i)) |=> !any_press_reg;
	endproperty
	a_press_clr: assert property (p_press_clr) else $error("press not cleared");

	// Full scale drops on a read unless a new peak arrives with it
	property p_full_clr;
		@(posedge clk_i) disable iff (rst_i)
		(status_rd && !(|full_hit)) |=> !full_scale_flag_reg;
	endproperty
	a_full_clr: assert property (p_full_clr) else $error("full scale not cleared");

	// A sequencer fault is never swallowed, even by a clearing read
	property p_seq_set;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && event_i.seq_fault) |=> sequencer_fault_flag_reg;
	endproperty
	a_seq_set: assert property (p_seq_set) else $error("seq fault lost");

	// Oscillator fault drops on a read with no new fault
	property p_osc_clr;
		@(posedge clk_i) disable iff (rst_i)
		(status_rd && !event_i.osc_fault) |=> !oscillator_start_fault_reg;
	endproperty
	a_osc_clr: assert property (p_osc_clr) else $error("osc fault not cleared");

	// Hold timeout drops on a read unless the limit is hit again
	property p_hold_clr;
		@(posedge clk_i) disable iff (rst_i)
		(status_rd && !timeout_hit) |=> !hold_timeout_reg;
	endproperty
	a_hold_clr: assert property (p_hold_clr) else $error("timeout not cleared");

	// Register integrity events always land in the flag
	property p_chg_set;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && event_i.reg_change) |=> reg_change_reg;
	endproperty
	a_chg_set: assert property (p_chg_set) else $error("reg change lost");

	// Integrity flag drops on a read with no new event
	property p_chg_clr;
		@(posedge clk_i) disable iff (rst_i)
		(status_rd && !event_i.reg_change) |=> !reg_change_reg;
	endproperty
	a_chg_clr: assert property (p_chg_clr) else $error("reg change not cleared");

	// New data flag, cleared by reading the button state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_ready_reg <= 1'b0;
		end else if (ce_i) begin
			data_ready_reg <= event_i.sample_done ||
				(data_ready_reg && !button_rd);
		end
	end

	// A new sample is flagged even when it meets a clearing read
	property p_new_set;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && event_i.sample_done) |=> data_ready_reg;
	endproperty
	a_new_set: assert property (p_new_set) else $error("new data lost");

	// ------------------------------------------------------------
	// Read mux, registered so data comes from a flip-flop
	// ------------------------------------------------------------
	always_comb begin
		rd_data_next = 8'h00;
		if (rd_req_i.addr == TSR_OFS_STATUS) begin
			rd_data_next[TSR_BIT_ANY_PRESS] = any_press_reg;
			rd_data_next[TSR_BIT_READY] = chip_ready_i;
			rd_data_next[TSR_BIT_WRITE_PERMIT] = write_permit_flag_i;
			rd_data_next[TSR_BIT_FULL_SCALE] = full_scale_flag_reg;
			rd_data_next[TSR_BIT_SEQ_FAULT] = sequencer_fault_flag_reg;
			rd_data_next[TSR_BIT_OSC_FAULT] = oscillator_start_fault_reg;
			rd_data_next[TSR_BIT_HOLD_TIMEOUT] = hold_timeout_reg;
			rd_data_next[TSR_BIT_REG_CHANGE] = reg_change_reg;
		end else if (rd_req_i.addr == TSR_OFS_BUTTON) begin
			rd_data_next = {3'b000, data_ready_reg, press_reg};
		end else begin
			for (int c = 0; c < TSR_RESULT_CHANNELS; c++) begin
				if (rd_req_i.addr == TSR_OFS_RESULT_BASE + 8'(2 * c)) begin
					rd_data_next = result_reg[c][7:0];
				end else if (rd_req_i.addr == TSR_OFS_RESULT_BASE + 8'(2 * c + 1)) begin
					rd_data_next = {4'h0, result_reg[c][11:8]};
				end
			end
		end
	end

	// Ready reads as one in reset so the status reset value holds
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_data_o <= TSR_RST_STATUS;
		end else if (ce_i && rd_req_i.rd) begin
			rd_data_o <= rd_data_next;
		end
	end

	// Ready and write permit are live levels, seen as they stood at the read
	property p_live;
		@(posedge clk_i) disable iff (rst_i)
		status_rd |=> (rd_data_o[TSR_BIT_READY] == $past(chip_ready_i)) &&
			(rd_data_o[TSR_BIT_WRITE_PERMIT] == $past(write_permit_flag_i));
	endproperty
	a_live: assert property (p_live) else $error("bad ready bits");

	// Bit 7 shows the press summary as it stood before the clear
	property p_bit7;
		@(posedge clk_i) disable iff (rst_i)
		status_rd |=> rd_data_o[TSR_BIT_ANY_PRESS] == $past(any_press_reg);
	endproperty
	a_bit7: assert property (p_bit7) else $error("bad press summary");

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_status_clear;
		@(posedge clk_i) disable iff (rst_i)
		(status_rd && !event_i.seq_fault) |=> !sequencer_fault_flag_reg;
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("seq fault not cleared");

	property p_set_wins;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && event_i.osc_fault) |=> oscillator_start_fault_reg;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("osc fault lost");

	property p_no_timeout;
		@(posedge clk_i) disable iff (rst_i)
		(hold_timeout_disable_i && !hold_timeout_reg) |=> !hold_timeout_reg;
	endproperty
	a_no_timeout: assert property (p_no_timeout) else $error("timeout while disabled");

	property p_msb_zero;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && rd_req_i.rd && rd_req_i.addr == 8'h03) |=> rd_data_o[7:4] == 4'h0;
	endproperty
	a_msb_zero: assert property (p_msb_zero) else $error("reserved bits set");

	property p_data_ready;
		@(posedge clk_i) disable iff (rst_i)
		(button_rd && !event_i.sample_done) |=> !data_ready_reg;
	endproperty
	a_data_ready: assert property (p_data_ready) else $error("data ready not cleared");

	property p_full;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && result_valid_i && result_data_i[11:0] == 12'h7ff) |=> full_scale_flag_reg;
	endproperty
	a_full: assert property (p_full) else $error("full scale missed");

	property p_any_press;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && |button_pressed_bits_i) |=> any_press_reg;
	endproperty
	a_any_press: assert property (p_any_press) else $error("press not flagged");

	property p_unmapped;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && rd_req_i.rd && rd_req_i.addr > 8'h07) |=> rd_data_o == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule // tsr_regs

// [testbench/tsr_host.sv]
// Host model that reads the status and result registers
`timescale 1ns/1ns

module tsr_host (
	input wire logic clk_i,
	input wire logic [7:0] data_i,
	output tsr_pkg::tsr_rd_req_s req_o
);
	import tsr_pkg::*;

	// Bus starts with the address on an unmapped offset; after a read the address stays on the last offset read
	initial req_o = '{rd: 1'b0, addr: 8'hff};

	// Reads only: the host never writes, so no reserved place is disturbed
	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk_i);
		#1;
		req_o.rd = 1'b1;
		req_o.addr = addr;
		@(posedge clk_i);
		#1;
		req_o.rd = 1'b0;
		data = data_i;
	endtask
endmodule // tsr_host

// [testbench/tsr_regs_tb.sv]
// Self-checking bench for the touch status and result registers
`timescale 1ns/1ns

module tsr_regs_tb;
	import tsr_pkg::*;

	// ------------------------------------------------------------
	// Signals and table of ordinary reads
	// ------------------------------------------------------------
	localparam longint HOLD = 20;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic chip_ready_i = 1'b1;
	logic write_permit_flag_i = 1'b0;
	logic hold_timeout_disable_i = 1'b0;
	logic [3:0] button_pressed_bits_i = 4'h0;
	tsr_event_s event_i = '0;
	logic result_valid_i = 1'b0;
	logic [35:0] result_data_i = 36'h0;
	tsr_rd_req_s rd_req;
	logic [7:0] rd_data_o;
	logic [7:0] d;
	int n_fail = 0;
	int tests_run = 0;
	logic [7:0] row_a [8] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h01, 8'hff};
	logic [7:0] row_e [8] = '{8'hff, 8'h07, 8'h23, 8'h01, 8'h00, 8'h08, 8'h00, 8'h00};

	always #5 clk_i = ~clk_i;

	tsr_regs #(.HOLD_TIMEOUT_CYC(HOLD)) u_dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.rd_req_i(rd_req),
		.rd_data_o(rd_data_o),
		.chip_ready_i(chip_ready_i),
		.write_permit_flag_i(write_permit_flag_i),
		.hold_timeout_disable_i(hold_timeout_disable_i),
		.button_pressed_bits_i(button_pressed_bits_i),
		.event_i(event_i),
		.result_valid_i(result_valid_i),
		.result_data_i(result_data_i)
	);

	tsr_host u_host (
		.clk_i(clk_i),
		.data_i(rd_data_o),
		.req_o(rd_req)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Inputs always move 1 ns after the edge, clear of the sampling point
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic test_done();
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog in case a read never returns
	initial begin
		#100000;
		n_fail++;
		test_done();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		step(2);
		rst_i = 1'b0;
		chk(rd_data_o, 8'h40);
		u_host.rd(8'h03, d);
		chk(d, 8'h00);
		write_permit_flag_i = 1'b1;
		result_valid_i = 1'b1;
		result_data_i = {12'h800, 12'h123, 12'h7ff};
		step(1);
		result_valid_i = 1'b0;
		for (int i = 0; i < 8; i++) begin
			u_host.rd(row_a[i], d);
			chk(d, row_e[i]);
		end
		u_host.rd(8'h00, d);
		chk(d, 8'h70);
		u_host.rd(8'h00, d);
		chk(d, 8'h60);
		event_i = '1;
		step(1);
		event_i = '0;
		u_host.rd(8'h00, d);
		chk(d, 8'h6d);
		u_host.rd(8'h01, d);
		chk(d, 8'h10);
		u_host.rd(8'h01, d);
		chk(d, 8'h00);
		// Long press with the timeout suppressed, then allowed
		hold_timeout_disable_i = 1'b1;
		button_pressed_bits_i = 4'h4;
		step(30);
		u_host.rd(8'h01, d);
		chk(d, 8'h04);
		u_host.rd(8'h00, d);
		chk(d, 8'he0);
		hold_timeout_disable_i = 1'b0;
		step(30);
		u_host.rd(8'h00, d);
		chk(d, 8'he2);
		button_pressed_bits_i = 4'h0;
		step(2);
		u_host.rd(8'h00, d);
		chk(d, 8'he0);
		u_host.rd(8'h00, d);
		chk(d, 8'h60);
		// Fault arrives in the very cycle the clearing read is taken
		fork
			u_host.rd(8'h00, d);
			begin
				@(posedge clk_i);
				#1;
				event_i.osc_fault = 1'b1;
				step(1);
				event_i.osc_fault = 1'b0;
			end
		join
		chk(d, 8'h60);
		u_host.rd(8'h00, d);
		chk(d, 8'h64);
		chip_ready_i = 1'b0;
		u_host.rd(8'h00, d);
		chk(d, 8'h20);
		// Reset in mid-run drops a pending fault and the stored results
		chip_ready_i = 1'b1;
		event_i.seq_fault = 1'b1;
		step(1);
		event_i.seq_fault = 1'b0;
		rst_i = 1'b1;
		step(2);
		rst_i = 1'b0;
		chk(rd_data_o, 8'h40);
		u_host.rd(8'h02, d);
		chk(d, 8'h00);
		u_host.rd(8'h00, d);
		chk(d, 8'h60);
		// A read with the clock enable low must leave the last answer standing
		ce_i = 1'b0;
		u_host.rd(8'h02, d);
		chk(d, 8'h60);
		test_done();
	end
endmodule // tsr_regs_tb
